// ---- bench/apb_host_model.sv ----
// Purpose: host-side apb master that stands in for the system controller
// Assumes: one request at a time, go held until done
// Notes: write data is inverted on release so stale data never looks valid
`timescale 1ns/1ns
`default_nettype none
module apb_host_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic go,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic done,
    output logic [31:0] rdata,
    output logic err
);
    assign pstrb = 4'hF;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {psel, penable, pwrite, done, err} <= 5'h0;
            paddr <= 8'h0;
            pwdata <= 32'h0;
            rdata <= 32'h0;
        end else begin
            done <= 1'b0;
            if (!psel && go && !done) begin
                {psel, pwrite, paddr, pwdata} <= {1'b1, wr, addr, wdata};
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (psel && pready) begin
                {psel, penable, done, err} <= {3'b001, pslverr};
                rdata <= prdata;
                pwdata <= ~pwdata;
            end
        end
    end
endmodule // apb_host_model
`default_nettype wire

// ---- bench/capacity_warning_flags_chk.sv ----
// Purpose: port-level assertions for the capacity warning flag block
// Assumes: one clock, reset active high
// Notes: the levels are not visible here, so only level-free bounds are checked
`timescale 1ns/1ns
`default_nettype none
module capacity_warning_flags_chk #(
    parameter int capacity_width = 16,
    parameter int level_width = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [capacity_width-1:0] remaining_capacity_value,
    input wire logic capacity_valid,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic low_battery_output,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence access_start;
        psel && $rose(penable);
    endsequence
    AST_ONE_WAIT: assert property (access_start |=> pready ##1 !pready) else $error("pready timing wrong");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_UNMAPPED: assert property (access_start ##0 paddr > 8'h1C |=> pslverr) else $error("no error");
    AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    AST_PIN_NEEDS_SAMPLE: assert property (!capacity_valid |=> $stable(low_battery_output))
        else $error("pin moved without sample");
    AST_HIGH_CLEARS: assert property (capacity_valid && (remaining_capacity_value >> level_width) != 0
        |=> !low_battery_output) else $error("pin high above any level");
    AST_FALL_CAUSE: assert property ($fell(low_battery_output) |-> $past(capacity_valid)
        && $past(remaining_capacity_value) != 0) else $error("pin cleared on equal zero");
    AST_RISE_CAUSE: assert property ($rose(low_battery_output) |-> $past(capacity_valid)
        && $past(remaining_capacity_value) < ((1 << level_width) - 1)) else $error("pin set wrongly");
endmodule // capacity_warning_flags_chk
bind capacity_warning_flags capacity_warning_flags_chk #(.capacity_width(capacity_width),
    .level_width(level_width)) i_capacity_warning_flags_chk (.core_clk(core_clk), .reset(reset),
    .remaining_capacity_value(remaining_capacity_value), .capacity_valid(capacity_valid), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .low_battery_output(low_battery_output), .irq(irq));
`default_nettype wire

// ---- bench/capacity_warning_flags_tb_top.sv ----
// Purpose: self-checking bench for the capacity warning flag block
// Assumes: default levels 150/175/75/100 after reset
// Notes: each sample is given three cycles so irq has settled before a check
`timescale 1ns/1ns
`default_nettype none
module capacity_warning_flags_tb_top;
    logic core_clk, reset, capacity_valid, go, wr, done, err, psel, penable, pwrite, pready, pslverr;
    logic low_battery_output, irq;
    logic [15:0] remaining_capacity_value;
    logic [7:0] addr, paddr;
    logic [31:0] wdata, rdata, prdata, pwdata;
    logic [3:0] pstrb;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    capacity_warning_flags i_capacity_warning_flags (.core_clk(core_clk), .reset(reset),
        .remaining_capacity_value(remaining_capacity_value), .capacity_valid(capacity_valid), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .low_battery_output(low_battery_output), .irq(irq));
    apb_host_model i_apb_host_model (.core_clk(core_clk), .reset(reset), .go(go), .wr(wr), .addr(addr),
        .wdata(wdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .done(done), .rdata(rdata), .err(err));
    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {go, wr, addr, wdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        while (done !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        go <= 1'b0;
        if (n == 20) n_mismatch++;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rdata);
    endtask
    task automatic sample(input logic [15:0] v);
        @(posedge core_clk);
        {capacity_valid, remaining_capacity_value} <= {1'b1, v};
        @(posedge core_clk);
        {capacity_valid, remaining_capacity_value} <= {1'b0, ~v};
        repeat (3) @(posedge core_clk);
    endtask
    // flags word: final enabled, valid seen, final, initial
    function automatic logic [31:0] fw(input logic [3:0] b);
        return {28'h0, b};
    endfunction
    task automatic t_reset_values();
        rd("init set", capacity_warning_pkg::off_initial_set, 32'(capacity_warning_pkg::rst_initial_set));
        rd("init clr", capacity_warning_pkg::off_initial_clear, 32'(capacity_warning_pkg::rst_initial_clear));
        rd("final set", capacity_warning_pkg::off_final_set, 32'(capacity_warning_pkg::rst_final_set));
        rd("final clr", capacity_warning_pkg::off_final_clear, 32'(capacity_warning_pkg::rst_final_clear));
        rd("flags", capacity_warning_pkg::off_flags, fw(4'h8));
        chk("pin", 32'h0, 32'(low_battery_output));
    endtask
    task automatic t_initial();
        sample(16'd150);
        rd("flags eq set", capacity_warning_pkg::off_flags, fw(4'hC));
        sample(16'd149);
        chk("pin set", 32'h1, 32'(low_battery_output));
        sample(16'd175);
        rd("flags eq clr", capacity_warning_pkg::off_flags, fw(4'hD));
        sample(16'd176);
        chk("pin clr", 32'h0, 32'(low_battery_output));
        rd("capacity", capacity_warning_pkg::off_capacity, 32'd176);
    endtask
    task automatic t_final();
        sample(16'd75);
        rd("final eq set", capacity_warning_pkg::off_flags, fw(4'hD));
        sample(16'd74);
        rd("final set", capacity_warning_pkg::off_flags, fw(4'hF));
        sample(16'd100);
        rd("final eq clr", capacity_warning_pkg::off_flags, fw(4'hF));
        sample(16'd101);
        rd("final clr", capacity_warning_pkg::off_flags, fw(4'hD));
        bus(1'b1, capacity_warning_pkg::off_final_set, 32'h0);
        sample(16'd10);
        rd("final off", capacity_warning_pkg::off_flags, fw(4'h5));
        bus(1'b1, capacity_warning_pkg::off_final_set, 32'd75);
        bus(1'b1, capacity_warning_pkg::off_flags, 32'h0);
        sample(16'd200);
        rd("all clear", capacity_warning_pkg::off_flags, fw(4'hC));
    endtask
    task automatic t_irq();
        chk("irq masked", 32'h0, 32'(irq));
        rd("status", capacity_warning_pkg::off_int_status, 32'hF);
        bus(1'b1, capacity_warning_pkg::off_int_mask, 32'hF);
        repeat (2) @(posedge core_clk);
        chk("irq on", 32'h1, 32'(irq));
        bus(1'b1, capacity_warning_pkg::off_int_status, 32'hF);
        repeat (2) @(posedge core_clk);
        chk("irq w1c", 32'h0, 32'(irq));
        sample(16'd149);
        rd("status set", capacity_warning_pkg::off_int_status, 32'h1);
        chk("irq event", 32'h1, 32'(irq));
        bus(1'b1, capacity_warning_pkg::off_int_mask, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("irq mask", 32'h0, 32'(irq));
        sample(16'd300);
        chk("pin above range", 32'h0, 32'(low_battery_output));
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rdata);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        {reset, capacity_valid, go, wr, addr, wdata, remaining_capacity_value} <= {3'b100, 1'b0, 8'h0, 32'h0, 16'h0};
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        t_reset_values();
        t_initial();
        t_final();
        t_irq();
        give_verdict();
    end
endmodule // capacity_warning_flags_tb_top
`default_nettype wire

// ---- src/capacity_warning_flags.sv ----
// Purpose: low-capacity warning flags with hysteresis, apb registers and interrupt
// Assumes: remaining capacity comes from gauging logic on core_clk with a valid strobe
// Notes: apb answers with one wait state so that read data leaves a flip-flop
//
// How it works
// R01: initial flag sets when remaining capacity falls below the initial set level.
// R02: initial flag clears only when capacity rises above the separate clear level.
// R03: low battery pin always follows the initial flag without software action.
// R04: final flag sets when remaining capacity falls below the final set level.
// R05: a final set level of zero disables the final flag entirely.
// R06: final flag clears above its clear level, and only while it is set.
// R07: both flags are readable bits of the flags word over the bus.
// R08: capacity and all four levels use one unit, mAh, compared directly.
// R09: after reset flags and pin stay low until a valid sample is compared.
// R10: comparisons are strict; equal values neither set nor clear.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module capacity_warning_flags #(
    parameter int capacity_width = 16,
    parameter int level_width = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    // remaining capacity from the gauging logic, mAh
    input wire logic [capacity_width-1:0] remaining_capacity_value,
    input wire logic capacity_valid,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // pins
    output logic low_battery_output,
    output logic irq
);

    initial begin
        if (level_width < 1 || level_width > 8) begin
            $error("capacity_warning_flags: level_width must be 1..8");
        end
        if (capacity_width < level_width || capacity_width > 32) begin
            $error("capacity_warning_flags: capacity_width out of range");
        end
    end

    // threshold registers, mAh
    logic [level_width-1:0] initial_warning_set_level;
    logic [level_width-1:0] initial_warning_clear_level;
    logic [level_width-1:0] final_warning_set_level;
    logic [level_width-1:0] final_warning_clear_level;

    logic [capacity_width-1:0] last_capacity;
    logic sample_seen;
    logic [capacity_warning_pkg::int_width-1:0] int_status;
    logic [capacity_warning_pkg::int_width-1:0] int_mask;
    logic [capacity_warning_pkg::int_width-1:0] int_events;
    logic [capacity_warning_pkg::int_width-1:0] w1c_bits;

    logic initial_capacity_warning;
    logic final_capacity_warning;
    logic final_enabled;
    logic initial_set_event;
    logic initial_clear_event;
    logic final_set_event;
    logic final_clear_event;

    capacity_warning_pkg::bus_state_e bus_state;
    logic access;
    logic wr_take;
    logic addr_mapped;
    logic [31:0] next_rdata;

    // ---------------- flag engines ----------------

    assign final_enabled = final_warning_set_level !=
        capacity_warning_pkg::final_disable_level[level_width-1:0]; // see R05

    // capacity and levels go to the comparators unscaled, all in mAh
    hysteresis_flag #(
        .value_width(capacity_width),
        .level_width(level_width)
    ) initial_flag_unit (
        .core_clk(core_clk),
        .reset(reset),
        .sample_valid(capacity_valid),
        .value(remaining_capacity_value), // see R08
        .set_level(initial_warning_set_level),
        .clear_level(initial_warning_clear_level),
        .enable(1'b1),
        .flag(initial_capacity_warning),
        .set_event(initial_set_event),
        .clear_event(initial_clear_event)
    );

    hysteresis_flag #(
        .value_width(capacity_width),
        .level_width(level_width)
    ) final_flag_unit (
        .core_clk(core_clk),
        .reset(reset),
        .sample_valid(capacity_valid),
        .value(remaining_capacity_value), // see R08
        .set_level(final_warning_set_level),
        .clear_level(final_warning_clear_level),
        .enable(final_enabled),
        .flag(final_capacity_warning),
        .set_event(final_set_event),
        .clear_event(final_clear_event)
    );

    // pin is the flag flop itself, so it can never disagree with the flags word
    assign low_battery_output = initial_capacity_warning; // see R03

    // last sample, kept for software to see what the flags were judged on
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            last_capacity <= '0;
            sample_seen <= 1'b0; // see R09
        end else if (capacity_valid) begin
            last_capacity <= remaining_capacity_value;
            sample_seen <= 1'b1;
        end
    end

    // ---------------- apb slave ----------------

    assign access = psel && penable;
    assign wr_take = access && pwrite && (bus_state == capacity_warning_pkg::bus_answer);

    always_comb begin
        addr_mapped = 1'b1;
        next_rdata = 32'h0000_0000;
        case (paddr)
            capacity_warning_pkg::off_initial_set: begin
                next_rdata[level_width-1:0] = initial_warning_set_level;
            end
            capacity_warning_pkg::off_initial_clear: begin
                next_rdata[level_width-1:0] = initial_warning_clear_level;
            end
            capacity_warning_pkg::off_final_set: begin
                next_rdata[level_width-1:0] = final_warning_set_level;
            end
            capacity_warning_pkg::off_final_clear: begin
                next_rdata[level_width-1:0] = final_warning_clear_level;
            end
            capacity_warning_pkg::off_flags: begin
                next_rdata[capacity_warning_pkg::flag_initial_bit] = initial_capacity_warning; // see R07
                next_rdata[capacity_warning_pkg::flag_final_bit] = final_capacity_warning; // see R07
                next_rdata[capacity_warning_pkg::flag_valid_bit] = sample_seen;
                next_rdata[capacity_warning_pkg::flag_final_enabled_bit] = final_enabled;
            end
            capacity_warning_pkg::off_capacity: begin
                next_rdata[capacity_width-1:0] = last_capacity;
            end
            capacity_warning_pkg::off_int_status: begin
                next_rdata[capacity_warning_pkg::int_width-1:0] = int_status;
            end
            capacity_warning_pkg::off_int_mask: begin
                next_rdata[capacity_warning_pkg::int_width-1:0] = int_mask;
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    // one wait state: answer registered in the first access cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bus_state <= capacity_warning_pkg::bus_idle;
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            case (bus_state)
                capacity_warning_pkg::bus_idle: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (access) begin
                        bus_state <= capacity_warning_pkg::bus_answer;
                        pready <= 1'b1;
                        pslverr <= ~addr_mapped;
                        prdata <= (pwrite || !addr_mapped) ? 32'h0000_0000 : next_rdata;
                    end
                end
                capacity_warning_pkg::bus_answer: begin
                    bus_state <= capacity_warning_pkg::bus_idle;
                    pready <= 1'b0;
                    // read data lives for the answer cycle only, so stale words never linger
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b0;
                end
                default: begin
                    bus_state <= capacity_warning_pkg::bus_idle;
                    prdata <= 32'h0000_0000;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // threshold writes; only the low byte lane carries a level
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            initial_warning_set_level <= capacity_warning_pkg::rst_initial_set[level_width-1:0];
            initial_warning_clear_level <= capacity_warning_pkg::rst_initial_clear[level_width-1:0];
            final_warning_set_level <= capacity_warning_pkg::rst_final_set[level_width-1:0];
            final_warning_clear_level <= capacity_warning_pkg::rst_final_clear[level_width-1:0];
        end else if (wr_take && pstrb[0]) begin
            case (paddr)
                capacity_warning_pkg::off_initial_set: begin
                    initial_warning_set_level <= pwdata[level_width-1:0];
                end
                capacity_warning_pkg::off_initial_clear: begin
                    initial_warning_clear_level <= pwdata[level_width-1:0];
                end
                capacity_warning_pkg::off_final_set: begin
                    final_warning_set_level <= pwdata[level_width-1:0];
                end
                capacity_warning_pkg::off_final_clear: begin
                    final_warning_clear_level <= pwdata[level_width-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------- interrupts ----------------

    assign int_events = {final_clear_event, final_set_event, initial_clear_event, initial_set_event};
    assign w1c_bits = (wr_take && pstrb[0] && paddr == capacity_warning_pkg::off_int_status)
        ? pwdata[capacity_warning_pkg::int_width-1:0] : '0;

    // a new event in the clearing cycle survives: set beats clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~w1c_bits) | int_events;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            int_mask <= capacity_warning_pkg::rst_int_mask;
        end else if (wr_take && pstrb[0] && paddr == capacity_warning_pkg::off_int_mask) begin
            int_mask <= pwdata[capacity_warning_pkg::int_width-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

endmodule // capacity_warning_flags
`default_nettype wire

// ---- src/capacity_warning_pkg.sv ----
// Purpose: shared constants for the capacity warning flag block
// Assumes: apb with 32-bit data, byte addresses, one aligned word per register
// Notes: threshold reset values are the documented level defaults in mAh
package capacity_warning_pkg;

    // register byte offsets
    localparam logic [7:0] off_initial_set = 8'h00;
    localparam logic [7:0] off_initial_clear = 8'h04;
    localparam logic [7:0] off_final_set = 8'h08;
    localparam logic [7:0] off_final_clear = 8'h0C;
    localparam logic [7:0] off_flags = 8'h10;
    localparam logic [7:0] off_capacity = 8'h14;
    localparam logic [7:0] off_int_status = 8'h18;
    localparam logic [7:0] off_int_mask = 8'h1C;

    // flags word bit positions
    localparam int flag_initial_bit = 0;
    localparam int flag_final_bit = 1;
    localparam int flag_valid_bit = 2;
    localparam int flag_final_enabled_bit = 3;

    // interrupt status / mask bit positions
    localparam int int_initial_set_bit = 0;
    localparam int int_initial_clear_bit = 1;
    localparam int int_final_set_bit = 2;
    localparam int int_final_clear_bit = 3;
    localparam int int_width = 4;

    // reset values of the thresholds, mAh
    localparam logic [7:0] rst_initial_set = 8'h96;
    localparam logic [7:0] rst_initial_clear = 8'hAF;
    localparam logic [7:0] rst_final_set = 8'h4B;
    localparam logic [7:0] rst_final_clear = 8'h64;
    localparam logic [int_width-1:0] rst_int_mask = 4'h0;

    // a final set level of this value switches the final warning off
    localparam logic [7:0] final_disable_level = 8'h00;

    // apb answer state
    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_answer = 2'b01
    } bus_state_e;

endpackage

// ---- src/hysteresis_flag.sv ----
// Purpose: one warning flag with separate set and clear levels
// Assumes: value and levels share one unit; sample_valid is a one-cycle strobe
// Notes: comparisons are strict; the flag moves only on a valid sample, or drops at once when enable is low
`timescale 1ns/1ns
`default_nettype none
module hysteresis_flag #(
    parameter int value_width = 16,
    parameter int level_width = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic [value_width-1:0] value,
    input wire logic [level_width-1:0] set_level,
    input wire logic [level_width-1:0] clear_level,
    input wire logic enable,
    output logic flag,
    output logic set_event,
    output logic clear_event
);

    logic [value_width-1:0] set_wide;
    logic [value_width-1:0] clear_wide;
    logic below_set;
    logic above_clear;

    initial begin
        if (level_width > value_width) begin
            $error("hysteresis_flag: level wider than value");
        end
    end

    // zero-extend the levels so that the compare is unsigned and lossless
    assign set_wide = {{(value_width-level_width){1'b0}}, set_level};
    assign clear_wide = {{(value_width-level_width){1'b0}}, clear_level};
    assign below_set = value < set_wide; // see R10
    assign above_clear = value > clear_wide; // see R10

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flag <= 1'b0; // see R09
            set_event <= 1'b0;
            clear_event <= 1'b0;
        end else begin
            set_event <= 1'b0;
            clear_event <= 1'b0;
            if (!enable) begin
                // a disabled flag is dropped at once, not left stale
                flag <= 1'b0; // see R05
                clear_event <= flag;
            end else if (sample_valid) begin
                // set wins if levels are misprogrammed to overlap
                if (below_set) begin
                    flag <= 1'b1; // see R01 see R04
                    set_event <= ~flag;
                end else if (above_clear && flag) begin
                    flag <= 1'b0; // see R02 see R06
                    clear_event <= 1'b1;
                end
            end
        end
    end

endmodule // hysteresis_flag
`default_nettype wire
